// ---- logic/wvcd_pkg.sv ----
// constants and carrier types of the write-and-verify command decoder
// assumes a single clock domain; shared by the decoder and its bench
`default_nettype none
package wvcd_pkg;
   localparam int CDB_MAX = 32;
   localparam logic [5:0] IDX_FULL = 6'h20;
   localparam logic [5:0] LEN_WV12 = 6'h0C;
   localparam logic [5:0] LEN_WV16 = 6'h10;
   localparam logic [5:0] LEN_WV32 = 6'h20;
   localparam logic [7:0] OPC_WV12 = 8'hAE;
   localparam logic [7:0] OPC_WV16 = 8'h8E;
   localparam logic [7:0] OPC_VARLEN = 8'h7F;
   localparam logic [15:0] SA_WV32 = 16'h000C;
   localparam logic [7:0] ADD_LEN_WV32 = 8'h18;
   localparam logic [2:0] PTYPE_2 = 3'h1;
   // byte positions inside the descriptor block
   localparam int B_OPC = 0;
   localparam int B_FLAGS = 1;
   localparam int B12_LBA = 2;
   localparam int B12_LEN = 6;
   localparam int B12_RSVD = 10;
   localparam int B16_LBA = 2;
   localparam int B16_LEN = 10;
   localparam int B16_RSVD = 14;
   localparam int B32_RSVD = 2;
   localparam int B32_GROUP = 6;
   localparam int B32_ADDLEN = 7;
   localparam int B32_SA = 8;
   localparam int B32_FLAGS = 10;
   localparam int B32_RSVD2 = 11;
   localparam int B32_LBA = 12;
   localparam int B32_REFTAG = 20;
   localparam int B32_APPTAG = 24;
   localparam int B32_MASK = 26;
   localparam int B32_LEN = 28;
   // bit positions inside the flags byte
   localparam int F_PROT_HI = 7;
   localparam int F_PROT_LO = 5;
   localparam int F_HINT = 4;
   localparam int F_CMPSEL = 1;
   localparam logic [7:0] RSVD_MASK_SHORT = 8'h08;
   localparam logic [7:0] RSVD_MASK_32 = 8'h0D;
   localparam int RET_W = 4;
   localparam logic [RET_W-1:0] RET_LOWEST = 4'hF;

   typedef logic [CDB_MAX-1:0][7:0] wvcd_cdb_t;

   typedef enum logic [2:0] {
      RES_GOOD,
      RES_BAD_OPCODE,
      RES_BAD_FIELD,
      RES_MEDIUM_ERROR,
      RES_MISCOMPARE
   } wvcd_res_t;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_FLUSH,
      OP_SEEK,
      OP_WRITE,
      OP_VERIFY_ECC,
      OP_VERIFY_CMP
   } wvcd_op_t;

   typedef struct packed {
      wvcd_res_t        result;
      logic             is32;
      logic [63:0]      lba;
      logic [31:0]      xfer_len;
      logic [31:0]      ref_tag;
      logic [15:0]      app_tag;
      logic [15:0]      app_mask;
      logic             check_app;
      logic [2:0]       protect_check_select;
      logic             low_retention_hint;
      logic             byte_compare_select;
      logic [RET_W-1:0] retention;
   } wvcd_cmd_t;
endpackage
`default_nettype wire

// ---- logic/wvcd_decoder.sv ----
// write-and-verify descriptor decoder: collects bytes, checks, queues, sequences ops
// assumes config inputs and op_done/op_fail come from logic on sys_clk
`default_nettype none
module wvcd_decoder #(
   parameter int BUF_DEPTH = 2
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic                     cdb_valid,
   input  wire logic [7:0]               cdb_byte,
   input  wire logic                     cdb_last,
   output var  logic                     cdb_ready,
   input  wire logic                     protection_enabled,
   input  wire logic [2:0]               protection_type,
   input  wire logic                     app_tag_owner,
   input  wire logic                     write_cache_enabled,
   input  wire logic [wvcd_pkg::RET_W-1:0] cfg_retention,
   output var  logic                     op_valid,
   output var  wvcd_pkg::wvcd_op_t       op_kind,
   output var  wvcd_pkg::wvcd_cmd_t      op_cmd,
   input  wire logic                     op_done,
   input  wire logic                     op_fail,
   output var  logic                     done_valid,
   output var  wvcd_pkg::wvcd_res_t      done_result
);
   import wvcd_pkg::*;

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam int CW = $clog2(BUF_DEPTH + 1);

   typedef enum logic {PH_COLLECT, PH_DECODE} wvcd_phase_t;

   typedef struct packed {
      wvcd_phase_t                 phase;
      logic [5:0]                  idx;
      logic                        over;
      wvcd_cdb_t                   cdb;
      logic                        cdb_ready;
      wvcd_cmd_t [BUF_DEPTH-1:0]   fifo;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               cnt;
      wvcd_op_t                    op;
      logic                        op_valid;
      wvcd_cmd_t                   cur;
      logic                        done_valid;
      wvcd_res_t                   done_result;
   } wvcd_state_t;

   wvcd_state_t st;
   wvcd_state_t next_st;
   wvcd_cmd_t   dec;
   logic [7:0]  fl;
   logic        push;
   logic        pop;

   function automatic logic [31:0] be32(input wvcd_cdb_t c, input int s);
      be32 = {c[s], c[s+1], c[s+2], c[s+3]};
   endfunction

   function automatic logic [15:0] be16(input wvcd_cdb_t c, input int s);
      be16 = {c[s], c[s+1]};
   endfunction

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(BUF_DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   // a zero-length command still flushes first when the write cache is enabled, but then only seeks
   function automatic wvcd_op_t first_op(input wvcd_cmd_t c);
      first_op = (c.xfer_len == 32'h00000000) ? OP_SEEK : OP_WRITE;
   endfunction

   // decoding looks at config at the decode cycle, not at execution time
   always_comb begin
      dec = '0;
      dec.result = RES_GOOD;
      fl = 8'h00;
      unique case (st.cdb[B_OPC])
         OPC_WV12: begin
            fl = st.cdb[B_FLAGS];
            dec.lba = {32'h00000000, be32(st.cdb, B12_LBA)};
            dec.xfer_len = be32(st.cdb, B12_LEN);
            if (st.over || st.idx != LEN_WV12 || (fl & RSVD_MASK_SHORT) != 8'h00
                || st.cdb[B12_RSVD] != 8'h00) begin
               dec.result = RES_BAD_FIELD;
            end
         end
         OPC_WV16: begin
            fl = st.cdb[B_FLAGS];
            dec.lba = {be32(st.cdb, B16_LBA), be32(st.cdb, B16_LBA + 4)};
            dec.xfer_len = be32(st.cdb, B16_LEN);
            if (st.over || st.idx != LEN_WV16 || (fl & RSVD_MASK_SHORT) != 8'h00
                || st.cdb[B16_RSVD] != 8'h00) begin
               dec.result = RES_BAD_FIELD;
            end
         end
         OPC_VARLEN: begin
            fl = st.cdb[B32_FLAGS];
            dec.is32 = 1'b1;
            dec.lba = {be32(st.cdb, B32_LBA), be32(st.cdb, B32_LBA + 4)};
            dec.ref_tag = be32(st.cdb, B32_REFTAG);
            dec.xfer_len = be32(st.cdb, B32_LEN);
            if (be16(st.cdb, B32_SA) != SA_WV32) begin
               dec.result = RES_BAD_OPCODE;
            end else if (!(protection_enabled && protection_type == PTYPE_2)) begin
               dec.result = RES_BAD_OPCODE;
            end else if (st.over || st.idx != LEN_WV32 || st.cdb[B32_ADDLEN] != ADD_LEN_WV32
                         || be32(st.cdb, B32_RSVD) != 32'h00000000
                         || st.cdb[B32_GROUP] != 8'h00 || st.cdb[B32_RSVD2] != 8'h00
                         || (fl & RSVD_MASK_32) != 8'h00) begin
               dec.result = RES_BAD_FIELD;
            end
            if (app_tag_owner) begin
               dec.app_tag = be16(st.cdb, B32_APPTAG);
               dec.app_mask = be16(st.cdb, B32_MASK);
               dec.check_app = |be16(st.cdb, B32_MASK);
            end
         end
         default: begin
            dec.result = RES_BAD_OPCODE;
         end
      endcase
      dec.protect_check_select = fl[F_PROT_HI:F_PROT_LO];
      dec.low_retention_hint = fl[F_HINT];
      dec.byte_compare_select = fl[F_CMPSEL];
      dec.retention = fl[F_HINT] ? RET_LOWEST : cfg_retention;
   end

   always_comb begin
      next_st = st;
      next_st.done_valid = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      if (st.phase == PH_COLLECT) begin
         if (cdb_valid && st.cdb_ready) begin
            if (st.idx < IDX_FULL) begin
               next_st.cdb[st.idx[4:0]] = cdb_byte;
               next_st.idx = st.idx + 6'h01;
            end else begin
               next_st.over = 1'b1;
            end
            if (cdb_last) begin
               next_st.phase = PH_DECODE;
            end
         end
      end else if (st.cnt < CW'(BUF_DEPTH)) begin
         // a full queue holds the decode and so stalls the byte stream
         push = 1'b1;
         next_st.fifo[st.wr] = dec;
         next_st.wr = ptr_inc(st.wr);
         next_st.phase = PH_COLLECT;
         next_st.idx = 6'h00;
         next_st.over = 1'b0;
      end
      next_st.cdb_ready = (next_st.phase == PH_COLLECT);

      if (!st.op_valid) begin
         if (st.cnt != '0) begin
            pop = 1'b1;
            next_st.rd = ptr_inc(st.rd);
            next_st.cur = st.fifo[st.rd];
            if (st.fifo[st.rd].result != RES_GOOD) begin
               next_st.done_valid = 1'b1;
               next_st.done_result = st.fifo[st.rd].result;
            end else begin
               next_st.op_valid = 1'b1;
               next_st.op = write_cache_enabled ? OP_FLUSH : first_op(st.fifo[st.rd]);
            end
         end
      end else if (op_done) begin
         next_st.op_valid = 1'b0;
         next_st.op = OP_NONE;
         next_st.done_result = op_fail ? RES_MEDIUM_ERROR : RES_GOOD;
         next_st.done_valid = 1'b1;
         unique case (st.op)
            OP_FLUSH: begin
               if (!op_fail) begin
                  next_st.done_valid = 1'b0;
                  next_st.op_valid = 1'b1;
                  next_st.op = first_op(st.cur);
               end
            end
            OP_WRITE: begin
               if (!op_fail) begin
                  next_st.done_valid = 1'b0;
                  next_st.op_valid = 1'b1;
                  next_st.op = st.cur.byte_compare_select ? OP_VERIFY_CMP : OP_VERIFY_ECC;
               end
            end
            OP_VERIFY_CMP: begin
               next_st.done_result = op_fail ? RES_MISCOMPARE : RES_GOOD;
            end
            default: begin
               // seek and ecc verify: failure is a medium error
               next_st.done_result = op_fail ? RES_MEDIUM_ERROR : RES_GOOD;
            end
         endcase
      end
      next_st.cnt = st.cnt + CW'(push) - CW'(pop);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cdb_ready = st.cdb_ready;
   assign op_valid = st.op_valid;
   assign op_kind = st.op;
   assign op_cmd = st.cur;
   assign done_valid = st.done_valid;
   assign done_result = st.done_result;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   wire decode_now = (st.phase == PH_DECODE) && push;
   sequence s_write_ok;
      st.op == OP_WRITE && op_done && !op_fail;
   endsequence
   sequence s_start_good;
      !st.op_valid && st.cnt != '0 && st.fifo[st.rd].result == RES_GOOD;
   endsequence

   AST_LBA12: assert property (decode_now && st.cdb[B_OPC] == OPC_WV12 |=>
      st.fifo[$past(st.wr)].lba[31:0] == be32($past(st.cdb), B12_LBA)
      && st.fifo[$past(st.wr)].xfer_len == be32($past(st.cdb), B12_LEN))
      else $error("12-byte address or length misplaced");
   AST_FLAGS: assert property (decode_now && st.cdb[B_OPC] == OPC_WV16 |=>
      st.fifo[$past(st.wr)].protect_check_select == $past(st.cdb[B_FLAGS][F_PROT_HI:F_PROT_LO])
      && st.fifo[$past(st.wr)].byte_compare_select == $past(st.cdb[B_FLAGS][F_CMPSEL]))
      else $error("flag byte fields misplaced");
   AST_LEN16: assert property (decode_now && st.cdb[B_OPC] == OPC_WV16
      && st.idx != LEN_WV16 |=> st.fifo[$past(st.wr)].result == RES_BAD_FIELD)
      else $error("16-byte length mismatch accepted");
   AST_ADDLEN: assert property (decode_now && st.cdb[B_OPC] == OPC_VARLEN
      && dec.result == RES_GOOD |-> st.cdb[B32_ADDLEN] == ADD_LEN_WV32
      && st.cdb[B32_GROUP] == 8'h00) else $error("bad 32-byte header accepted");
   AST_SA: assert property (decode_now && st.cdb[B_OPC] == OPC_VARLEN
      && be16(st.cdb, B32_SA) != SA_WV32 |-> dec.result == RES_BAD_OPCODE)
      else $error("foreign service action accepted");
   AST_REFTAG: assert property (decode_now && dec.is32 |->
      dec.ref_tag == be32(st.cdb, B32_REFTAG) && dec.xfer_len == be32(st.cdb, B32_LEN))
      else $error("reference tag or length misplaced");
   AST_PTYPE: assert property (decode_now && dec.is32 && dec.result == RES_GOOD |->
      protection_enabled && protection_type == PTYPE_2)
      else $error("32-byte command accepted without type 2");
   AST_MASK: assert property (decode_now && dec.is32 |->
      dec.app_mask == (app_tag_owner ? be16(st.cdb, B32_MASK) : 16'h0000)
      && (app_tag_owner || !dec.check_app)) else $error("tag mask gating wrong");
   AST_ORDER: assert property (s_write_ok |=> st.op_valid
      && (st.op == OP_VERIFY_ECC || st.op == OP_VERIFY_CMP) && !st.done_valid)
      else $error("verify did not follow write");
   AST_FLUSH: assert property (s_start_good ##0 write_cache_enabled |=>
      st.op == OP_FLUSH ##1 st.op == OP_FLUSH [*1]) else $error("no flush first");
   AST_MISCMP: assert property (st.op == OP_VERIFY_CMP && op_done && op_fail |=>
      done_valid && done_result == RES_MISCOMPARE) else $error("miscompare not reported");
   AST_SEEK: assert property (st.op == OP_SEEK && op_done && !op_fail |=>
      done_valid && done_result == RES_GOOD) else $error("zero length reported as error");
   AST_RET: assert property (decode_now |->
      dec.retention == (dec.low_retention_hint ? RET_LOWEST : cfg_retention))
      else $error("retention priority wrong");
endmodule
`default_nettype wire

// ---- tb/wvcd_op_model.sv ----
// far-side drive machinery model: answers each requested op after a set delay
// assumes the decoder's op handshake, all on sys_clk
`default_nettype none
module wvcd_op_model (
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   input  wire logic               op_valid,
   input  wire wvcd_pkg::wvcd_op_t op_kind,
   input  wire logic [3:0]         dly,
   input  wire wvcd_pkg::wvcd_op_t fail_op,
   output var  logic               op_done,
   output var  logic               op_fail
);
   timeunit 1ns;
   timeprecision 100ps;
   import wvcd_pkg::*;
   logic [3:0] cnt;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 4'h0;
         op_done <= 1'b0;
         op_fail <= 1'b0;
      end else if (op_valid && !op_done && cnt == dly) begin
         op_done <= 1'b1;
         op_fail <= (op_kind == fail_op);
         cnt <= 4'h0;
      end else begin
         op_done <= 1'b0;
         // fail flag carries no meaning outside a done pulse, so keep it moving
         op_fail <= ~op_fail;
         cnt <= (op_valid && !op_done) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

// ---- tb/write_verify_cdb_decoder_tb_top.sv ----
// self-checking bench of the write-and-verify descriptor decoder
// assumes wvcd_pkg, the decoder and wvcd_op_model are compiled before it
`default_nettype none
module write_verify_cdb_decoder_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import wvcd_pkg::*;
   typedef struct packed {
      logic [7:0] opc; logic [5:0] n; logic [31:0] xlen; logic [7:0] flags;
      logic [7:0] pidx; logic [7:0] pval; logic cache; logic pen; logic [2:0] ptype;
      logic owner; logic [15:0] mask; wvcd_op_t fop; wvcd_res_t res;
   } wvcd_row_t;
   logic       sys_clk, rstn, cdb_valid, cdb_last, cdb_ready, protection_enabled;
   logic [7:0] cdb_byte;
   logic [2:0] protection_type;
   logic       app_tag_owner, write_cache_enabled, op_valid, op_done, op_fail, done_valid;
   logic [3:0] cfg_retention, dly;
   wvcd_op_t   op_kind, fail_op;
   wvcd_cmd_t  op_cmd;
   wvcd_res_t  done_result;
   wvcd_res_t  res_q[$];
   wvcd_op_t   ops_q[$];
   wvcd_cmd_t  cmd_q[$];
   int         error_cnt = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   wvcd_row_t  rows[18] = '{
      '{8'hAE,6'h0C,32'h5,8'h02,8'hFF,8'h0,1'b1,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_GOOD},
      '{8'h8E,6'h10,32'h0,8'h10,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_GOOD},
      '{8'h7F,6'h20,32'h9,8'h32,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b1,16'h0F0F,OP_VERIFY_CMP,
        RES_MISCOMPARE},
      '{8'h7F,6'h20,32'h9,8'h00,8'hFF,8'h0,1'b1,1'b1,3'h1,1'b0,16'hFFFF,OP_WRITE,
        RES_MEDIUM_ERROR},
      '{8'h7F,6'h20,32'h9,8'h00,8'hFF,8'h0,1'b0,1'b1,3'h2,1'b0,16'h0,OP_NONE,RES_BAD_OPCODE},
      '{8'h7F,6'h20,32'h9,8'h00,8'hFF,8'h0,1'b0,1'b0,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_OPCODE},
      '{8'h7F,6'h20,32'h9,8'h00,8'h09,8'h0B,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_OPCODE},
      '{8'h7F,6'h20,32'h9,8'h00,8'h07,8'h17,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'h7F,6'h20,32'h9,8'h00,8'h03,8'h01,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'hAE,6'h0C,32'h5,8'h00,8'h0A,8'h01,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'hAE,6'h0C,32'h5,8'h08,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'hAE,6'h10,32'h5,8'h00,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'hAA,6'h10,32'h5,8'h00,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_OPCODE},
      '{8'h7F,6'h22,32'h9,8'h00,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'h8E,6'h10,32'h7,8'hE0,8'hFF,8'h0,1'b1,1'b1,3'h1,1'b0,16'h0,OP_VERIFY_ECC,
        RES_MEDIUM_ERROR},
      '{8'h7F,6'h20,32'h9,8'h00,8'h06,8'h01,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'h8E,6'h0C,32'h7,8'h00,8'hFF,8'h0,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD},
      '{8'h8E,6'h10,32'h7,8'h00,8'h0E,8'h01,1'b0,1'b1,3'h1,1'b0,16'h0,OP_NONE,RES_BAD_FIELD}};
   wvcd_decoder dut_u (.sys_clk(sys_clk), .rstn(rstn), .cdb_valid(cdb_valid),
      .cdb_byte(cdb_byte), .cdb_last(cdb_last), .cdb_ready(cdb_ready),
      .protection_enabled(protection_enabled), .protection_type(protection_type),
      .app_tag_owner(app_tag_owner), .write_cache_enabled(write_cache_enabled),
      .cfg_retention(cfg_retention), .op_valid(op_valid), .op_kind(op_kind),
      .op_cmd(op_cmd), .op_done(op_done), .op_fail(op_fail), .done_valid(done_valid),
      .done_result(done_result));
   wvcd_op_model model_u (.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid),
      .op_kind(op_kind), .dly(dly), .fail_op(fail_op), .op_done(op_done), .op_fail(op_fail));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (done_valid === 1'b1) res_q.push_back(done_result);
      if (op_valid === 1'b1 && op_done === 1'b1) begin
         ops_q.push_back(op_kind);
         cmd_q.push_back(op_cmd);
      end
      // ceiling well above the several hundred cycles the run needs
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic check(logic [63:0] got, logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [63:0] be(wvcd_cdb_t c, int s, int k);
      logic [63:0] v;
      v = '0;
      for (int i = 0; i < k; i++) v = {v[55:0], c[s+i]};
      return v;
   endfunction
   function automatic wvcd_cdb_t build(wvcd_row_t r);
      wvcd_cdb_t c;
      for (int i = 0; i < 32; i++) c[i] = 8'h10 + 8'(i);
      c[0] = r.opc;
      if (r.opc == OPC_VARLEN) begin
         {c[2], c[3], c[4], c[5], c[6]} = 40'h0;
         {c[7], c[8], c[9], c[10], c[11]} = {ADD_LEN_WV32, SA_WV32, r.flags, 8'h00};
         {c[26], c[27], c[28], c[29], c[30], c[31]} = {r.mask, r.xlen};
      end else begin
         c[1] = r.flags;
         if (r.opc == OPC_WV12) {c[6], c[7], c[8], c[9], c[10], c[11]} = {r.xlen, 16'h0};
         else {c[10], c[11], c[12], c[13], c[14], c[15]} = {r.xlen, 16'h0};
      end
      if (r.pidx < 8'h20) c[r.pidx[4:0]] = r.pval;
      return c;
   endfunction
   // byte stream handshake: launched just after an edge, held until taken
   task automatic send(wvcd_cdb_t c, int n);
      for (int i = 0; i < n; i++) begin
         cdb_valid <= 1'b1;
         cdb_byte <= c[i%32];
         cdb_last <= (i == n - 1);
         do @(posedge sys_clk); while (cdb_ready !== 1'b1);
      end
      cdb_valid <= 1'b0;
      cdb_last <= 1'b0;
   endtask
   task automatic run_row(wvcd_row_t r);
      wvcd_cdb_t c;
      wvcd_op_t  exp_q[$];
      logic      is32;
      int        nx;
      c = build(r);
      is32 = (r.opc == OPC_VARLEN);
      {protection_enabled, protection_type, app_tag_owner} <= {r.pen, r.ptype, r.owner};
      write_cache_enabled <= r.cache;
      fail_op <= r.fop;
      res_q.delete();
      ops_q.delete();
      cmd_q.delete();
      send(c, int'(r.n));
      while (res_q.size() < 1) @(posedge sys_clk);
      check(res_q[0], r.res);
      if (r.res inside {RES_GOOD, RES_MEDIUM_ERROR, RES_MISCOMPARE}) begin
         if (r.cache) exp_q.push_back(OP_FLUSH);
         exp_q.push_back(r.xlen == 32'h0 ? OP_SEEK : OP_WRITE);
         // zero length only seeks: nothing was written, so nothing is verified
         if (r.xlen != 32'h0) exp_q.push_back(r.flags[1] ? OP_VERIFY_CMP : OP_VERIFY_ECC);
      end
      nx = exp_q.size();
      for (int k = exp_q.size() - 1; k >= 0; k--) if (exp_q[k] == r.fop) nx = k + 1;
      check(ops_q.size(), nx);
      for (int k = 0; k < ops_q.size() && k < nx; k++) check(ops_q[k], exp_q[k]);
      if (cmd_q.size() > 0) begin
         check(cmd_q[0].lba, is32 ? be(c, 12, 8) : be(c, 2, r.opc == OPC_WV12 ? 4 : 8));
         check(cmd_q[0].xfer_len, r.xlen);
         check(cmd_q[0].is32, is32);
         if (is32) check(cmd_q[0].ref_tag, be(c, 20, 4));
         check({cmd_q[0].app_tag, cmd_q[0].app_mask, cmd_q[0].check_app},
               (is32 && r.owner) ? {be(c, 24, 4), r.mask != 16'h0} : 33'h0);
         check(cmd_q[0].retention, r.flags[4] ? RET_LOWEST : 4'h5);
         check({cmd_q[0].protect_check_select, cmd_q[0].low_retention_hint,
                cmd_q[0].byte_compare_select}, {r.flags[7:4], r.flags[1]});
      end
   endtask
   initial begin
      {rstn, cdb_valid, cdb_last, cdb_byte, app_tag_owner, write_cache_enabled} = '0;
      {protection_enabled, protection_type, cfg_retention} = {1'b1, 3'h1, 4'h5};
      {dly, fail_op} = {4'h1, OP_NONE};
      repeat (16) @(posedge sys_clk);
      check({cdb_ready, op_valid, done_valid, op_kind, done_result}, 64'h0);
      check({63'h0, op_cmd === '0}, 64'h1);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1 check(cdb_ready, 1'b1);
      $display("test reset done");
      @(posedge sys_clk);
      foreach (rows[i]) begin
         dly <= 4'(i % 3);
         run_row(rows[i]);
         $display("test row %0d done", i);
      end
      // slow far side so a decoded command waits in the queue behind the running op
      dly <= 4'h8;
      fail_op <= OP_NONE;
      res_q.delete();
      send(build(rows[0]), 12);
      @(posedge sys_clk);
      send(build(rows[1]), 16);
      @(posedge sys_clk);
      send(build(rows[9]), 12);
      @(posedge sys_clk);
      send(build(rows[12]), 16);
      while (res_q.size() < 4) @(posedge sys_clk);
      check({res_q[0], res_q[1], res_q[2], res_q[3]},
            {RES_GOOD, RES_GOOD, RES_BAD_FIELD, RES_BAD_OPCODE});
      $display("test back_to_back done");
      // reset while an op is requested: every output drops, then a fresh command runs
      send(build(rows[14]), 16);
      while (op_valid !== 1'b1) @(posedge sys_clk);
      rstn <= 1'b0;
      @(posedge sys_clk);
      #1 check({cdb_ready, op_valid, done_valid, op_kind, done_result}, 64'h0);
      @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1 check(cdb_ready, 1'b1);
      @(posedge sys_clk);
      dly <= 4'h0;
      run_row(rows[0]);
      $display("test midrun_reset done");
      close_out();
   end
endmodule
`default_nettype wire
